/* hw/aod_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
// Registered decoder of arithmetic opcode pair
module aod_decoder (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    input  wire logic        i_valid,
    input  wire logic [7:0]  i_byte0,
    input  wire logic [7:0]  i_byte1,
    input  wire logic [7:0]  i_imm_lo,
    output logic             o_valid,
    output logic             o_recognised,
    output logic [3:0]       o_op,
    output logic [1:0]       o_form,
    output logic             o_word,
    output logic             o_slot_is_dest,
    output logic             o_uses_modrm,
    output logic [1:0]       o_data_bytes,
    output logic             o_sign_extend,
    output logic [15:0]      o_imm_ext,
    output logic [1:0]       o_mode,
    output logic [2:0]       o_slot,
    output logic [2:0]       o_locator
);
    aod_fields_if fields ();

    aod_modrm_split u_split (
        .i_byte (i_byte1),
        .fields (fields)
    );

    logic       w_bit;
    logic       d_bit;
    logic [2:0] ext;
    assign w_bit = i_byte0[aod_pkg::AOD_W_BIT];
    assign d_bit = i_byte0[aod_pkg::AOD_D_BIT];
    assign ext   = fields.slot;

    // Opcode class match wires
    wire hit_sum_rr   = i_byte0[7:2] == aod_pkg::AOD_SUM_RR;
    wire hit_sumc_rr  = i_byte0[7:2] == aod_pkg::AOD_SUMC_RR;
    wire hit_sumc_acc = i_byte0[7:1] == aod_pkg::AOD_SUMC_ACC;
    wire hit_diff_rr  = i_byte0[7:2] == aod_pkg::AOD_DIFF_RR;
    wire hit_diff_acc = i_byte0[7:1] == aod_pkg::AOD_DIFF_ACC;
    wire hit_dfb_rr   = i_byte0[7:2] == aod_pkg::AOD_DIFFB_RR;
    wire hit_dfb_acc  = i_byte0[7:1] == aod_pkg::AOD_DIFFB_ACC;
    wire hit_imm_rm   = i_byte0[7:2] == aod_pkg::AOD_IMM_RM;
    wire hit_grp3     = i_byte0[7:1] == aod_pkg::AOD_GRP3;
    wire hit_apf      = (i_byte0 == aod_pkg::AOD_APF_BYTE)
                        && (i_byte1 == aod_pkg::AOD_ASCII_BASE);
    wire hit_aqp      = (i_byte0 == aod_pkg::AOD_AQP_BYTE)
                        && (i_byte1 == aod_pkg::AOD_ASCII_BASE);
    wire hit_asf      = i_byte0 == aod_pkg::AOD_ASF_BYTE;
    wire hit_bsf      = i_byte0 == aod_pkg::AOD_BSF_BYTE;

    // Immediate group: only sum, carry sum, difference, borrow kept
    wire imm_sum   = hit_imm_rm && (ext == aod_pkg::AOD_EXT_SUM);
    wire imm_sumc  = hit_imm_rm && (ext == aod_pkg::AOD_EXT_SUMC);
    wire imm_diff  = hit_imm_rm && (ext == aod_pkg::AOD_EXT_DIFF);
    wire imm_dfb   = hit_imm_rm && (ext == aod_pkg::AOD_EXT_DIFFB);
    wire imm_any   = imm_sum || imm_sumc || imm_diff || imm_dfb;

    // Product and quotient group selected by extension
    wire g3_uprod  = hit_grp3 && (ext == aod_pkg::AOD_EXT_UPROD);
    wire g3_sprod  = hit_grp3 && (ext == aod_pkg::AOD_EXT_SPROD);
    wire g3_uquot  = hit_grp3 && (ext == aod_pkg::AOD_EXT_UQUOT);
    wire g3_squot  = hit_grp3 && (ext == aod_pkg::AOD_EXT_SQUOT);
    wire g3_any    = g3_uprod || g3_sprod || g3_uquot || g3_squot;

    wire rr_any    = hit_sum_rr || hit_sumc_rr || hit_diff_rr || hit_dfb_rr;
    wire acc_any   = hit_sumc_acc || hit_diff_acc || hit_dfb_acc;

    // Operation select, priority irrelevant since classes are disjoint
    aod_pkg::aod_op_e next_op;
    always_comb begin
        next_op = aod_pkg::AOD_OP_NONE;
        if (hit_sum_rr || imm_sum) begin
            next_op = aod_pkg::AOD_OP_SUM;
        end else if (hit_sumc_rr || hit_sumc_acc || imm_sumc) begin
            next_op = aod_pkg::AOD_OP_SUM_CARRY;
        end else if (hit_diff_rr || hit_diff_acc || imm_diff) begin
            next_op = aod_pkg::AOD_OP_DIFFERENCE;
        end else if (hit_dfb_rr || hit_dfb_acc || imm_dfb) begin
            next_op = aod_pkg::AOD_OP_DIFFERENCE_WITH_BORROW;
        end else if (g3_uprod) begin
            next_op = aod_pkg::AOD_OP_UNSIGNED_PRODUCT;
        end else if (g3_sprod) begin
            next_op = aod_pkg::AOD_OP_SIGNED_PRODUCT;
        end else if (g3_uquot) begin
            next_op = aod_pkg::AOD_OP_UNSIGNED_QUOTIENT;
        end else if (g3_squot) begin
            next_op = aod_pkg::AOD_OP_SIGNED_QUOTIENT;
        end else if (hit_apf) begin
            next_op = aod_pkg::AOD_OP_ASCII_PRODUCT_FIXUP;
        end else if (hit_aqp) begin
            next_op = aod_pkg::AOD_OP_ASCII_QUOTIENT_PREP;
        end else if (hit_asf) begin
            next_op = aod_pkg::AOD_OP_ASCII_SUM_FIXUP;
        end else if (hit_bsf) begin
            next_op = aod_pkg::AOD_OP_BCD_SUM_FIXUP;
        end
    end

    // Form of operands
    aod_pkg::aod_form_e next_form;
    assign next_form = (rr_any || g3_any) ? aod_pkg::AOD_FORM_REG_RM :
                       imm_any            ? aod_pkg::AOD_FORM_IMM_RM :
                       acc_any            ? aod_pkg::AOD_FORM_IMM_ACC :
                                            aod_pkg::AOD_FORM_NONE;

    // Width only meaningful for forms carrying a w bit
    wire has_w          = rr_any || g3_any || imm_any || acc_any;
    wire next_word      = has_w && w_bit;
    wire next_dest      = rr_any && d_bit;
    wire s_bit          = i_byte0[aod_pkg::AOD_S_BIT];
    wire next_uses_mrm  = rr_any || g3_any || imm_any;

    // Data byte count: s:w 01 for reg/mem immediates, w for accumulator
    wire [1:0] next_data_bytes =
        imm_any ? ((!s_bit && w_bit) ? 2'h2 : 2'h1) :
        acc_any ? (w_bit ? 2'h2 : 2'h1) :
                  2'h0;

    // Sign extension of a single immediate byte to word
    wire next_sext = imm_any && s_bit && w_bit;
    wire [15:0] next_imm_ext = next_sext ? {{8{i_imm_lo[7]}}, i_imm_lo} :
                                           {8'h00, i_imm_lo};

    // Outputs registered; a clock-enable stall freezes them
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_valid        <= 1'b0;
            o_recognised   <= 1'b0;
            o_op           <= 4'h0;
            o_form         <= 2'h0;
            o_word         <= 1'b0;
            o_slot_is_dest <= 1'b0;
            o_uses_modrm   <= 1'b0;
            o_data_bytes   <= 2'h0;
            o_sign_extend  <= 1'b0;
            o_imm_ext      <= 16'h0000;
            o_mode         <= 2'h0;
            o_slot         <= 3'h0;
            o_locator      <= 3'h0;
        end else if (i_ce) begin
            o_valid        <= i_valid;
            o_recognised   <= i_valid && (next_op != aod_pkg::AOD_OP_NONE);
            o_op           <= next_op;
            o_form         <= next_form;
            o_word         <= next_word;
            o_slot_is_dest <= next_dest;
            o_uses_modrm   <= next_uses_mrm;
            o_data_bytes   <= next_data_bytes;
            o_sign_extend  <= next_sext;
            o_imm_ext      <= next_imm_ext;
            o_mode         <= fields.mode;
            o_slot         <= fields.slot;
            o_locator      <= fields.locator;
        end
    end
endmodule : aod_decoder
`default_nettype wire

/* inc/aod_pkg.sv */
// Functional notes
// - 000000dw is register/memory sum, modrm follows
// - carry sum register form and accumulator immediate
// - difference register, accumulator, extension 101 forms
// - borrow difference register, accumulator, extension 011 forms
// - second data byte when s:w 01 or w
// - 1111011w extension 100 is unsigned product
// - extension 101 is signed product
// - extension 110 is unsigned quotient
// - extension 111 is signed quotient
// - D4 then 0A is ascii product fixup
// - D5 then 0A is ascii quotient prep
// - byte 37 is ascii sum fixup
// - byte 27 is bcd sum fixup
package aod_pkg;
    typedef enum logic [3:0] {
        AOD_OP_NONE,
        AOD_OP_SUM,
        AOD_OP_SUM_CARRY,
        AOD_OP_DIFFERENCE,
        AOD_OP_DIFFERENCE_WITH_BORROW,
        AOD_OP_UNSIGNED_PRODUCT,
        AOD_OP_SIGNED_PRODUCT,
        AOD_OP_UNSIGNED_QUOTIENT,
        AOD_OP_SIGNED_QUOTIENT,
        AOD_OP_ASCII_PRODUCT_FIXUP,
        AOD_OP_ASCII_QUOTIENT_PREP,
        AOD_OP_ASCII_SUM_FIXUP,
        AOD_OP_BCD_SUM_FIXUP
    } aod_op_e;

    typedef enum logic [1:0] {
        AOD_FORM_NONE,
        AOD_FORM_REG_RM,
        AOD_FORM_IMM_RM,
        AOD_FORM_IMM_ACC
    } aod_form_e;

    // Opcode prefixes, top six, seven or all eight bits of first byte; AOD_ASCII_BASE is the second byte
    localparam logic [5:0] AOD_SUM_RR      = 6'h00;
    localparam logic [5:0] AOD_SUMC_RR     = 6'h04;
    localparam logic [5:0] AOD_DIFF_RR     = 6'h0A;
    localparam logic [5:0] AOD_DIFFB_RR    = 6'h06;
    localparam logic [5:0] AOD_IMM_RM      = 6'h20;
    localparam logic [6:0] AOD_SUMC_ACC    = 7'h0A;
    localparam logic [6:0] AOD_DIFF_ACC    = 7'h16;
    localparam logic [6:0] AOD_DIFFB_ACC   = 7'h0E;
    localparam logic [6:0] AOD_GRP3        = 7'h7B;
    localparam logic [7:0] AOD_APF_BYTE    = 8'hD4;
    localparam logic [7:0] AOD_AQP_BYTE    = 8'hD5;
    localparam logic [7:0] AOD_ASCII_BASE  = 8'h0A;
    localparam logic [7:0] AOD_ASF_BYTE    = 8'h37;
    localparam logic [7:0] AOD_BSF_BYTE    = 8'h27;
    // Extension codes in second byte
    localparam logic [2:0] AOD_EXT_SUM     = 3'h0;
    localparam logic [2:0] AOD_EXT_SUMC    = 3'h2;
    localparam logic [2:0] AOD_EXT_DIFFB   = 3'h3;
    localparam logic [2:0] AOD_EXT_DIFF    = 3'h5;
    localparam logic [2:0] AOD_EXT_UPROD   = 3'h4;
    localparam logic [2:0] AOD_EXT_SPROD   = 3'h5;
    localparam logic [2:0] AOD_EXT_UQUOT   = 3'h6;
    localparam logic [2:0] AOD_EXT_SQUOT   = 3'h7;
    // Field positions
    localparam int AOD_W_BIT   = 0;
    localparam int AOD_D_BIT   = 1;
    localparam int AOD_S_BIT   = 1;
endpackage : aod_pkg

/* inc/aod_fields_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Second-byte fields passed from splitter to decoder
interface aod_fields_if;
    logic [1:0] mode;
    logic [2:0] slot;
    logic [2:0] locator;
    modport src (output mode, output slot, output locator);
    modport dst (input mode, input slot, input locator);
endinterface : aod_fields_if
`default_nettype wire

/* hw/aod_modrm_split.sv */
`timescale 1ns/1ps
`default_nettype none
// Splits the addressing byte into its three fields
module aod_modrm_split (
    input  wire logic [7:0] i_byte,
    aod_fields_if.src       fields
);
    // Pure wiring of fields
    assign fields.mode    = i_byte[7:6];
    assign fields.slot    = i_byte[5:3];
    assign fields.locator = i_byte[2:0];
endmodule : aod_modrm_split
`default_nettype wire

/* tb/aod_decoder_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches decoder ports; each decode lands one enabled edge after its bytes
module aod_decoder_chk (
    input wire logic        i_ref_clk,
    input wire logic        i_rstn,
    input wire logic        i_ce,
    input wire logic [7:0]  i_byte0,
    input wire logic [7:0]  i_byte1,
    input wire logic [7:0]  i_imm_lo,
    input wire logic [3:0]  o_op,
    input wire logic [1:0]  o_form,
    input wire logic        o_word,
    input wire logic [1:0]  o_data_bytes,
    input wire logic [15:0] o_imm_ext
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    property p_sum; i_ce && i_byte0[7:2] == 6'h00 |=> o_op == 4'h1 && o_form == 2'h1; endproperty
    a_sum: assert property (p_sum) else $error("sum form wrong");
    property p_sumc; i_ce && i_byte0[7:1] == 7'h0A |=> o_op == 4'h2 && o_form == 2'h3; endproperty
    a_sumc: assert property (p_sumc) else $error("carry sum form wrong");
    property p_diff; i_ce && i_byte0[7:2] == 6'h20 && i_byte1[5:3] == 3'h5 |=> o_op == 4'h3;
    endproperty
    a_diff: assert property (p_diff) else $error("difference form wrong");
    property p_diffb; i_ce && i_byte0[7:2] == 6'h06 |=> o_op == 4'h4; endproperty
    a_diffb: assert property (p_diffb) else $error("borrow form wrong");
    property p_len; i_ce && i_byte0[7:2] == 6'h20 && i_byte1[5:3] == 3'h5
        |=> o_data_bytes == (($past(i_byte0[1:0]) == 2'h1) ? 2'h2 : 2'h1); endproperty
    a_len: assert property (p_len) else $error("data byte count wrong");
    property p_grp; i_ce && i_byte0[7:1] == 7'h7B && i_byte1[5]
        |=> o_op == 4'h5 + {2'h0, $past(i_byte1[4:3])}; endproperty
    a_grp: assert property (p_grp) else $error("product or quotient wrong");
    property p_adj; i_ce && i_byte0[7:1] == 7'h6A && i_byte1 == 8'h0A
        |=> o_op == 4'h9 + {3'h0, $past(i_byte0[0])}; endproperty
    a_adj: assert property (p_adj) else $error("ascii pair wrong");
    property p_fix; i_ce && (i_byte0 & 8'hEF) == 8'h27
        |=> o_op == ($past(i_byte0[4]) ? 4'hB : 4'hC); endproperty
    a_fix: assert property (p_fix) else $error("sum fixup wrong");
    property p_word; i_ce && i_byte0[7:2] == 6'h0A |=> o_word == $past(i_byte0[0]); endproperty
    a_word: assert property (p_word) else $error("width bit wrong");
    property p_sext; i_ce && i_byte0 == 8'h83 && i_byte1[5:3] == 3'h5
        |=> o_imm_ext == {{8{$past(i_imm_lo[7])}}, $past(i_imm_lo)}; endproperty
    a_sext: assert property (p_sext) else $error("sign extension wrong");
endmodule : aod_decoder_chk
bind aod_decoder aod_decoder_chk u_chk (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_byte0(i_byte0), .i_byte1(i_byte1), .i_imm_lo(i_imm_lo), .o_op(o_op), .o_form(o_form),
    .o_word(o_word), .o_data_bytes(o_data_bytes), .o_imm_ext(o_imm_ext));
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        i_ref_clk = 1'b0;
    logic        i_rstn = 1'b0;
    logic        i_ce = 1'b1;
    logic        i_valid = 1'b0;
    logic [7:0]  i_byte0 = 8'h00, i_byte1 = 8'h00, i_imm_lo = 8'h00;
    logic        o_valid, o_recognised, o_word, o_slot_is_dest, o_uses_modrm, o_sign_extend;
    logic [3:0]  o_op;
    logic [1:0]  o_form, o_data_bytes, o_mode;
    logic [2:0]  o_slot, o_locator;
    logic [15:0] o_imm_ext;
    int          bad_count = 0, tests_run = 0;
    aod_decoder dut (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_valid(i_valid),
        .i_byte0(i_byte0), .i_byte1(i_byte1), .i_imm_lo(i_imm_lo), .o_valid(o_valid),
        .o_recognised(o_recognised), .o_op(o_op), .o_form(o_form), .o_word(o_word),
        .o_slot_is_dest(o_slot_is_dest), .o_uses_modrm(o_uses_modrm),
        .o_data_bytes(o_data_bytes), .o_sign_extend(o_sign_extend), .o_imm_ext(o_imm_ext),
        .o_mode(o_mode), .o_slot(o_slot), .o_locator(o_locator));
    always #5 i_ref_clk = ~i_ref_clk;
    task chk(input logic [15:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Called at a falling edge; returns at the next falling edge with the answer settled
    task apply(input logic [7:0] b0, b1, im);
        i_valid = 1'b1;
        {i_byte0, i_byte1, i_imm_lo} = {b0, b1, im};
        @(negedge i_ref_clk);
    endtask : apply
    // Register forms back to back, every direction and width
    task t_regs;
        logic [5:0]  pre [4];
        logic [15:0] want;
        pre = '{6'h00, 6'h04, 6'h0A, 6'h06};
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 4; k++) begin
                apply({pre[i], 2'(k)}, 8'hEA, 8'h00);
                chk(16'(o_op), 16'(i + 1));
                want = 16'({2'h1, k[0], k[1], 1'b1});
                chk(16'({o_form, o_word, o_slot_is_dest, o_uses_modrm}), want);
                chk(16'({o_data_bytes, o_mode, o_slot, o_locator}), 16'h00EA);
            end
        end
    endtask : t_regs
    // Sign flag, op, form and data byte count, then the extended immediate
    task imm(input logic [7:0] b0, b1, im, input logic [8:0] res, input logic [15:0] ext);
        apply(b0, b1, im);
        chk({7'h00, o_sign_extend, o_op, o_form, o_data_bytes}, {7'h00, res});
        chk(o_imm_ext, ext);
    endtask : imm
    task t_imm;
        imm(8'h81, 8'hE8, 8'hFF, 9'h03A, 16'h00FF);
        imm(8'h83, 8'hE8, 8'hFF, 9'h139, 16'hFFFF);
        imm(8'h83, 8'hE8, 8'h7F, 9'h139, 16'h007F);
        imm(8'h80, 8'hD8, 8'h80, 9'h049, 16'h0080);
        imm(8'h2D, 8'h00, 8'h00, 9'h03E, 16'h0000);
        imm(8'h2C, 8'h00, 8'h00, 9'h03D, 16'h0000);
        imm(8'h1D, 8'h00, 8'h00, 9'h04E, 16'h0000);
        imm(8'h1C, 8'h00, 8'h00, 9'h04D, 16'h0000);
        imm(8'h15, 8'h00, 8'h00, 9'h02E, 16'h0000);
        imm(8'h14, 8'h00, 8'h00, 9'h02D, 16'h0000);
        imm(8'h80, 8'hC8, 8'h00, 9'h000, 16'h0000);
        imm(8'h81, 8'hC0, 8'h12, 9'h01A, 16'h0012);
        imm(8'h83, 8'hD0, 8'h80, 9'h129, 16'hFF80);
    endtask : t_imm
    // Extensions 0xx are refused, 1xx pick product or quotient
    task t_grp3;
        logic [15:0] want;
        for (int e = 0; e < 8; e++) begin
            apply({7'h7B, e[0]}, {2'h3, 3'(e), 3'h0}, 8'h00);
            want = (e > 3) ? 16'({4'(e + 1), e[0]}) : 16'h0000;
            chk(16'({o_op, o_word}), want);
        end
    endtask : t_grp3
    // Adjust bytes, a broken pair, and a frozen edge with clock enable low
    task t_ascii;
        apply(8'hD4, 8'h0A, 8'h00);
        chk(16'({o_valid, o_recognised, o_op}), 16'h0039);
        apply(8'hD5, 8'h0A, 8'h00);
        chk(16'({o_valid, o_recognised, o_op}), 16'h003A);
        apply(8'hD4, 8'h0B, 8'h00);
        chk(16'({o_valid, o_recognised, o_op}), 16'h0020);
        apply(8'h37, 8'h55, 8'h00);
        chk(16'({o_valid, o_recognised, o_op}), 16'h003B);
        i_ce = 1'b0;
        apply(8'h27, 8'h55, 8'h00);
        chk(16'(o_op), 16'h000B);
        i_ce = 1'b1;
        apply(8'h27, 8'h55, 8'h00);
        chk(16'({o_valid, o_recognised, o_op}), 16'h003C);
    endtask : t_ascii
    // Mid-run reset clears outputs at once; idle cycle decodes but is not recognised
    task t_rst;
        i_rstn = 1'b0;
        #1;
        chk(16'({o_valid, o_recognised, o_op, o_form, o_word, o_slot_is_dest}), 16'h0000);
        chk(16'({o_uses_modrm, o_data_bytes, o_sign_extend, o_mode, o_slot, o_locator}), 16'h0000);
        chk(o_imm_ext, 16'h0000);
        @(negedge i_ref_clk);
        i_valid = 1'b0;
        {i_byte0, i_byte1, i_imm_lo} = {8'h37, 8'h00, 8'h00};
        i_rstn = 1'b1;
        @(negedge i_ref_clk);
        chk(16'({o_valid, o_recognised, o_op}), 16'h000B);
    endtask : t_rst
    task wrap_up;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // Reset held twelve cycles, o_valid and o_op must read zero at its end
    initial begin
        repeat (12) @(negedge i_ref_clk);
        chk(16'({o_valid, o_op}), 16'h0000);
        i_rstn = 1'b1;
        @(negedge i_ref_clk);
        t_regs();
        t_imm();
        t_grp3();
        t_ascii();
        t_rst();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
